// file: hdl/master_slave_pwm.v
// Master/slave PWM generator with APB register access
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "pwm_consts.vh"
module master_slave_pwm #(
   parameter CW = 16,
   parameter DW = 8
) (
   input wire ref_clk_i,
   input wire nrst_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   output wire pwm_out_o,
   output wire master_irq_o,
   output wire slave_irq_o
);

   //---------------------------------------------------------------
   // State
   //---------------------------------------------------------------
   reg gate_ff;
   reg m_en_ff;
   reg s_en_ff;
   reg [CW-1:0] period_ff;
   reg [CW-1:0] duty_ff;
   reg [CW-1:0] pcnt_ff;
   reg [CW-1:0] dcnt_ff;
   reg s_run_ff;
   reg act_ff;
   reg pin_ff;
   reg level_ff;
   reg oe_ff;
   reg pol_ff;
   reg mode_m_ff;
   reg mode_s_ff;
   reg split_ff;
   reg cksel_m_ff;
   reg cksel_s_ff;
   reg [2*DW-1:0] presc_ff;
   reg pready_ff;
   reg pslverr_ff;
   reg [31:0] prdata_ff;
   reg m_irq_ff;
   reg s_irq_ff;

   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign pwm_out_o = pin_ff;
   assign master_irq_o = m_irq_ff;
   assign slave_irq_o = s_irq_ff;

   //---------------------------------------------------------------
   // Bus decode
   //---------------------------------------------------------------
   wire busy;
   wire unit_clr;
   wire ask;
   wire done;
   wire wr;
   wire blocked;
   reg hit;
   reg [31:0] rdata;
   wire wr_ok;

   assign busy = m_en_ff | s_en_ff;
   // Gate low reinitialises everything but the gate and bus
   assign unit_clr = ~nrst_i | ~gate_ff;
   // One wait state keeps pready and prdata on flip-flops
   assign ask = psel_i & penable_i & ~pready_ff;
   assign done = psel_i & penable_i & pready_ff;
   assign wr = done & pwrite_i;
   assign blocked = ~gate_ff & (paddr_i != `OFS_CLK_GATE);
   assign wr_ok = wr & hit & ~blocked;

   always @* begin
      hit = 1'b1;
      rdata = `RD_ZERO;
      case (paddr_i)
         `OFS_CLK_GATE: begin
            rdata[0] = gate_ff;
         end
         // Trigger bits always read back as zero
         `OFS_START: begin
            rdata = `RD_ZERO;
         end
         `OFS_STOP: begin
            rdata = `RD_ZERO;
         end
         `OFS_STATUS: begin
            rdata[`BIT_MASTER] = m_en_ff;
            rdata[`BIT_SLAVE] = s_en_ff;
         end
         `OFS_PERIOD: begin
            rdata[CW-1:0] = period_ff;
         end
         `OFS_DUTY: begin
            rdata[CW-1:0] = duty_ff;
         end
         // Counters readable while counting
         `OFS_PCNT: begin
            rdata[CW-1:0] = pcnt_ff;
         end
         `OFS_DCNT: begin
            rdata[CW-1:0] = dcnt_ff;
         end
         `OFS_OUTCFG: begin
            rdata[`BIT_LEVEL] = level_ff;
            rdata[`BIT_OE] = oe_ff;
            rdata[`BIT_POL] = pol_ff;
            rdata[`BIT_MODE_M] = mode_m_ff;
            rdata[`BIT_MODE_S] = mode_s_ff;
            rdata[`BIT_SPLIT] = split_ff;
            rdata[`BIT_CKSEL_M] = cksel_m_ff;
            rdata[`BIT_CKSEL_S] = cksel_s_ff;
         end
         `OFS_PRESC: begin
            rdata[2*DW-1:0] = presc_ff;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   //---------------------------------------------------------------
   // Bus answer
   //---------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= `RD_ZERO;
      end else begin
         pready_ff <= ask;
         if (ask) begin
            pslverr_ff <= ~hit | blocked;
            if (blocked || pwrite_i) begin
               prdata_ff <= `RD_ZERO;
            end else begin
               prdata_ff <= rdata;
            end
         end else begin
            pslverr_ff <= 1'b0;
            prdata_ff <= `RD_ZERO;
         end
      end
   end

   //---------------------------------------------------------------
   // Triggers
   //---------------------------------------------------------------
   wire start_m;
   wire start_s;
   wire stop_m;
   wire stop_s;

   // Pulses only; nothing is stored, so the bits clear themselves
   assign start_m = wr_ok & (paddr_i == `OFS_START)
                    & pwdata_i[`BIT_MASTER];
   assign start_s = wr_ok & (paddr_i == `OFS_START)
                    & pwdata_i[`BIT_SLAVE];
   assign stop_m = wr_ok & (paddr_i == `OFS_STOP)
                   & pwdata_i[`BIT_MASTER];
   assign stop_s = wr_ok & (paddr_i == `OFS_STOP)
                   & pwdata_i[`BIT_SLAVE];

   //---------------------------------------------------------------
   // Prescaled count clocks
   //---------------------------------------------------------------
   wire [1:0] tick;
   wire tick_m;
   wire tick_s;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_presc
         clk_prescaler #(
            .W(DW)
         ) u_presc (
            .ref_clk_i(ref_clk_i),
            .nrst_i(nrst_i),
            .run_i(gate_ff),
            .div_i(presc_ff[g*DW +: DW]),
            .tick_o(tick[g])
         );
      end
   endgenerate

   // Each channel follows its own select; mismatched selects misbehave
   assign tick_m = cksel_m_ff ? tick[1] : tick[0];
   assign tick_s = cksel_s_ff ? tick[1] : tick[0];

   //---------------------------------------------------------------
   // Configuration registers
   //---------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         gate_ff <= 1'b0;
      end else if (wr && paddr_i == `OFS_CLK_GATE) begin
         gate_ff <= pwdata_i[0];
      end
   end

   always @(posedge ref_clk_i) begin
      if (unit_clr) begin
         period_ff <= `RST_RELOAD;
         duty_ff <= `RST_RELOAD;
         presc_ff <= `RST_PRESC;
         level_ff <= 1'b0;
         oe_ff <= 1'b0;
         pol_ff <= 1'b0;
         mode_m_ff <= 1'b0;
         mode_s_ff <= 1'b0;
         split_ff <= 1'b0;
         cksel_m_ff <= 1'b0;
         cksel_s_ff <= 1'b0;
      end else begin
         // Reloads are held here and only copied at a master event
         if (wr_ok && paddr_i == `OFS_PERIOD) begin
            period_ff <= pwdata_i[CW-1:0];
         end
         if (wr_ok && paddr_i == `OFS_DUTY) begin
            duty_ff <= pwdata_i[CW-1:0];
         end
         if (wr_ok && paddr_i == `OFS_PRESC && !busy) begin
            presc_ff <= pwdata_i[2*DW-1:0];
         end
         if (wr_ok && paddr_i == `OFS_OUTCFG) begin
            level_ff <= pwdata_i[`BIT_LEVEL];
            oe_ff <= pwdata_i[`BIT_OE];
            pol_ff <= pwdata_i[`BIT_POL];
            // Structural settings frozen while running
            if (!busy) begin
               mode_m_ff <= pwdata_i[`BIT_MODE_M];
               mode_s_ff <= pwdata_i[`BIT_MODE_S];
               split_ff <= pwdata_i[`BIT_SPLIT];
               cksel_m_ff <= pwdata_i[`BIT_CKSEL_M];
               cksel_s_ff <= pwdata_i[`BIT_CKSEL_S];
            end
         end
      end
   end

   //---------------------------------------------------------------
   // Enable status
   //---------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (unit_clr) begin
         m_en_ff <= 1'b0;
         s_en_ff <= 1'b0;
      end else begin
         // Start is written last so it wins over a same-cycle stop
         if (stop_m) begin
            m_en_ff <= 1'b0;
         end
         if (start_m) begin
            m_en_ff <= 1'b1;
         end
         if (stop_s) begin
            s_en_ff <= 1'b0;
         end
         if (start_s) begin
            s_en_ff <= 1'b1;
         end
      end
   end

   //---------------------------------------------------------------
   // Master channel
   //---------------------------------------------------------------
   wire m_run;
   wire m_evt;

   assign m_run = m_en_ff & ~stop_m & tick_m;
   // Event on start and on every underflow from zero
   assign m_evt = start_m | (m_run & (pcnt_ff == `CNT_ZERO));

   always @(posedge ref_clk_i) begin
      if (unit_clr) begin
         pcnt_ff <= `CNT_ONES;
         m_irq_ff <= 1'b0;
      end else begin
         m_irq_ff <= m_evt;
         if (m_evt) begin
            // Zero is one more tick, so period is reload plus one
            pcnt_ff <= period_ff;
         end else if (m_run) begin
            pcnt_ff <= pcnt_ff - {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end

   //---------------------------------------------------------------
   // Slave channel
   //---------------------------------------------------------------
   wire [CW-1:0] dmask;
   wire s_load;
   wire s_step;
   wire d_zero;
   wire s_end;

   assign dmask = split_ff ? `CNT_LOW : `CNT_ONES;
   assign s_load = m_evt & (s_en_ff | start_s) & ~stop_s;
   assign s_step = s_en_ff & s_run_ff & tick_s & ~stop_s;
   assign d_zero = (dcnt_ff & dmask) == `CNT_ZERO;
   // A reload on the same tick outranks the end, which keeps 100%
   assign s_end = s_step & ~s_load & d_zero;

   always @(posedge ref_clk_i) begin
      if (unit_clr) begin
         dcnt_ff <= `CNT_ONES;
         s_run_ff <= 1'b0;
         s_irq_ff <= 1'b0;
      end else begin
         s_irq_ff <= s_end;
         if (s_load) begin
            dcnt_ff <= duty_ff & dmask;
            s_run_ff <= 1'b1;
         end else if (s_end) begin
            dcnt_ff <= `CNT_ONES;
            s_run_ff <= 1'b0;
         end else if (s_step) begin
            dcnt_ff <= (dcnt_ff - {{(CW-1){1'b0}}, 1'b1}) & dmask;
         end
      end
   end

   //---------------------------------------------------------------
   // Output
   //---------------------------------------------------------------
   always @(posedge ref_clk_i) begin
      if (unit_clr) begin
         act_ff <= 1'b0;
      end else if (mode_s_ff) begin
         // Slave output mode: set on first tick, clear at zero
         if (s_end) begin
            act_ff <= 1'b0;
         end else if (s_step && !s_load) begin
            act_ff <= 1'b1;
         end
      end else if (s_end) begin
         // Master output mode just toggles on each end
         act_ff <= ~act_ff;
      end
   end

   // Stopped channels leave act_ff alone, so the pin holds
   always @(posedge ref_clk_i) begin
      if (unit_clr) begin
         pin_ff <= 1'b0;
      end else if (oe_ff) begin
         pin_ff <= act_ff ^ pol_ff;
      end else begin
         pin_ff <= level_ff;
      end
   end

endmodule // master_slave_pwm

// file: shared/pwm_consts.vh
// Constants for the master/slave PWM generator
//------------------------------------------------------------------
//------------------------------------------------------------------
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH

//------------------------------------------------------------------
// Register offsets
//------------------------------------------------------------------
`define OFS_CLK_GATE 8'h00
`define OFS_START 8'h04
`define OFS_STOP 8'h08
`define OFS_STATUS 8'h0c
`define OFS_PERIOD 8'h10
`define OFS_DUTY 8'h14
`define OFS_PCNT 8'h18
`define OFS_DCNT 8'h1c
`define OFS_OUTCFG 8'h20
`define OFS_PRESC 8'h24

//------------------------------------------------------------------
// Field positions
//------------------------------------------------------------------
`define BIT_MASTER 0
`define BIT_SLAVE 1
`define BIT_LEVEL 0
`define BIT_OE 1
`define BIT_POL 2
`define BIT_MODE_M 3
`define BIT_MODE_S 4
`define BIT_SPLIT 5
`define BIT_CKSEL_M 6
`define BIT_CKSEL_S 7

//------------------------------------------------------------------
// Reset values, masks and compare constants
//------------------------------------------------------------------
`define RST_RELOAD 16'h0000
`define RST_PRESC 16'h0000
`define CNT_ONES 16'hffff
`define CNT_LOW 16'h00ff
`define CNT_ZERO 16'h0000
`define RD_ZERO 32'h0000_0000

`endif

// file: hdl/clk_prescaler.v
// Divider that makes one count-clock tick every div plus one cycles
`timescale 1ns/1ns
module clk_prescaler #(
   parameter W = 8
) (
   input wire ref_clk_i,
   input wire nrst_i,
   input wire run_i,
   input wire [W-1:0] div_i,
   output wire tick_o
);

   reg [W-1:0] cnt_ff;
   reg tick_ff;

   assign tick_o = tick_ff;

   always @(posedge ref_clk_i) begin
      if (!nrst_i || !run_i) begin
         cnt_ff <= {W{1'b0}};
         tick_ff <= 1'b0;
      end else if (cnt_ff == div_i) begin
         cnt_ff <= {W{1'b0}};
         tick_ff <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
         tick_ff <= 1'b0;
      end
   end

endmodule // clk_prescaler

// file: tb/pwm_props.sv
// Checker on the PWM generator ports
`timescale 1ns/1ns
module pwm_props (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic pwm_out_o,
   input wire logic master_irq_o,
   input wire logic slave_irq_o
);
   //------------------------------------------
   // Gate shadow and port assertions
   //------------------------------------------
   logic gate_ff;
   logic wr_done;
   assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
   // Shadow of the gate bit, since it is not visible at the ports
   always @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         gate_ff <= 1'b0;
      end else if (wr_done && paddr_i == 8'h00) begin
         gate_ff <= pwdata_i[0];
      end
   end
   default clocking dc @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   ready_wait_a: assert property (
      psel_i && penable_i && !pready_o |=> pready_o)
      else $error("pready not in second access cycle");
   ready_once_a: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
      else $error("read data outside answer");
   gate_block_a: assert property (
      pready_o && !gate_ff && paddr_i != 8'h00 |-> pslverr_o)
      else $error("access not refused with gate off");
   unmapped_a: assert property (pready_o && paddr_i > 8'h24 |-> pslverr_o)
      else $error("unmapped access without error");
   start_event_a: assert property (
      wr_done && gate_ff && paddr_i == 8'h04 && pwdata_i[0] |=> master_irq_o)
      else $error("no master event after start");
   irq_pulse_a: assert property (master_irq_o |=> !master_irq_o)
      else $error("master event wider than one cycle");
   slave_pulse_a: assert property (slave_irq_o |=> !slave_irq_o)
      else $error("slave end event wider than one cycle");
   stop_hold_a: assert property (
      wr_done && gate_ff && paddr_i == 8'h08 && pwdata_i[1:0] == 2'b11
      |=> ##2 (!master_irq_o && $stable(pwm_out_o)) [*6])
      else $error("counting or pin change after stop");
   start_seen_c: cover property (wr_done && paddr_i == 8'h04);
   pwm_rise_c: cover property ($rose(pwm_out_o));
   slave_end_c: cover property (slave_irq_o);
endmodule // pwm_props

// file: tb/pwm_load.sv
// Load on the PWM pin that measures high time per period
`timescale 1ns/1ns
module pwm_load (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic pwm_i,
   input wire logic period_mark_i,
   output int high_cyc_o,
   output int per_cyc_o
);
   //------------------------------------------
   // Period and high time meter
   //------------------------------------------
   int high_acc_ff;
   int per_acc_ff;
   // Sums a whole period, so pulse phase does not matter
   always @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         high_acc_ff <= 0;
         per_acc_ff <= 0;
         high_cyc_o <= 0;
         per_cyc_o <= 0;
      end else if (period_mark_i) begin
         high_cyc_o <= high_acc_ff;
         per_cyc_o <= per_acc_ff;
         high_acc_ff <= pwm_i ? 1 : 0;
         per_acc_ff <= 1;
      end else begin
         high_acc_ff <= high_acc_ff + (pwm_i ? 1 : 0);
         per_acc_ff <= per_acc_ff + 1;
      end
   end
endmodule // pwm_load

// file: tb/tb_master_slave_pwm.sv
// Self-checking bench for the master/slave PWM generator
`timescale 1ns/1ns
module tb_master_slave_pwm;
   //------------------------------------------
   // Stimulus, model and checks
   //------------------------------------------
   localparam int TICK = 2; // Prescaler divider 1
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000;
   wire [31:0] prdata_o;
   wire pready_o, pslverr_o, pwm_out_o, master_irq_o, slave_irq_o;
   int high_cyc, per_cyc, error_cnt = 0, n_checks = 0, p, d, pol, a;
   logic [31:0] rd, c;
   logic err;
   always #5 ref_clk_i = ~ref_clk_i;
   master_slave_pwm dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .pwm_out_o(pwm_out_o),
      .master_irq_o(master_irq_o), .slave_irq_o(slave_irq_o));
   pwm_load load_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .pwm_i(pwm_out_o), .period_mark_i(master_irq_o),
      .high_cyc_o(high_cyc), .per_cyc_o(per_cyc));
   int sirq_acc = 0, sirq_per = 0;
   // Slave end events counted between two master marks
   always @(posedge ref_clk_i) begin
      if (master_irq_o) begin
         sirq_per <= sirq_acc;
         sirq_acc <= slave_irq_o ? 1 : 0;
      end else begin
         sirq_acc <= sirq_acc + (slave_irq_o ? 1 : 0);
      end
   end
   task finish_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
      n_checks++;
      if (got !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, got);
      end
   endtask
   task apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= ad;
      pwdata_i <= wd;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 50) begin
         error_cnt++;
         finish_test();
      end
   endtask
   task rd_chk(input logic [7:0] ad, input logic [31:0] e, input string nm);
      apb(1'b0, ad, 0);
      chk(nm, rd, e);
   endtask
   task wait_irq(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(posedge ref_clk_i);
            k++;
         end while (master_irq_o !== 1'b1 && k < 200);
         if (k >= 200) begin
            error_cnt++;
            finish_test();
         end
      end
      #1;
   endtask
   function automatic int act_cyc(int pp, int dd);
      return ((dd > pp + 1) ? pp + 1 : dd) * TICK;
   endfunction
   initial begin
      void'($urandom(63141));
      repeat (3) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      apb(1'b0, 8'h0c, 0);
      chk("gated error", err, 1);
      apb(1'b1, 8'h10, 32'h0000_0005);
      apb(1'b1, 8'h00, 32'h0000_0001);
      rd_chk(8'h10, 0, "gated write");
      apb(1'b0, 8'h40, 0);
      chk("unmapped error", err, 1);
      apb(1'b1, 8'h24, 32'h0000_0001); // Clock a, divider 1
      apb(1'b1, 8'h20, 32'h0000_0012);
      // Zero period at start would give two events in a row
      apb(1'b1, 8'h10, 32'h0000_0005);
      apb(1'b1, 8'h04, 32'h0000_0003);
      rd_chk(8'h0c, 32'h0000_0003, "status run");
      rd_chk(8'h04, 0, "start clear");
      $display("test start done");
      for (int i = 0; i < 6; i++) begin
         p = $urandom_range(2, 7);
         d = (i == 0) ? 0 : (i == 1) ? p + 1 : (i == 2) ? p + 3
            : $urandom_range(1, p);
         pol = i % 2;
         wait_irq(1);
         apb(1'b1, 8'h10, p);
         apb(1'b1, 8'h14, d);
         apb(1'b1, 8'h20, 32'h0000_0012 | (pol << 2));
         wait_irq(3);
         a = pol ? (p + 1) * TICK - act_cyc(p, d) : act_cyc(p, d);
         chk("period", per_cyc, (p + 1) * TICK);
         chk("active", high_cyc, a);
         chk("slave ends", sirq_per, (d <= p) ? 1 : 0);
         apb(1'b0, 8'h18, 0);
         chk("pcnt range", rd <= p, 1);
      end
      $display("test duty table done");
      apb(1'b1, 8'h08, 32'h0000_0003);
      rd_chk(8'h0c, 0, "status stop");
      apb(1'b0, 8'h18, 0);
      c = rd;
      repeat (8) @(posedge ref_clk_i);
      rd_chk(8'h18, c, "pcnt hold");
      apb(1'b1, 8'h20, 32'h0000_0032);
      d = $urandom_range(1, 7);
      apb(1'b1, 8'h10, 7);
      apb(1'b1, 8'h14, 32'h0000_0300 | d);
      apb(1'b1, 8'h04, 32'h0000_0003);
      wait_irq(4);
      chk("split active", high_cyc, d * TICK);
      apb(1'b1, 8'h08, 32'h0000_0003);
      repeat (10) @(posedge ref_clk_i);
      apb(1'b1, 8'h20, 32'h0000_0002); // Master output mode
      apb(1'b1, 8'h14, 32'h0000_0002);
      apb(1'b1, 8'h04, 32'h0000_0003);
      wait_irq(3);
      c = pwm_out_o;
      wait_irq(1);
      chk("toggle pin", pwm_out_o, !c[0]);
      apb(1'b1, 8'h08, 32'h0000_0003);
      repeat (10) @(posedge ref_clk_i);
      $display("test stop and split done");
      for (int lv = 0; lv < 2; lv++) begin
         apb(1'b1, 8'h20, 32'h0000_0030 | lv);
         repeat (4) @(posedge ref_clk_i);
         chk("level pin", pwm_out_o, lv);
      end
      apb(1'b1, 8'h00, 0);
      repeat (4) @(posedge ref_clk_i);
      chk("gated pin", pwm_out_o, 0);
      apb(1'b1, 8'h00, 32'h0000_0001);
      rd_chk(8'h1c, 32'h0000_ffff, "dcnt cleared");
      rd_chk(8'h20, 0, "cfg cleared");
      $display("test level and gate done");
      finish_test();
   end
   // Whole run needs under a thousand cycles; this leaves wide margin
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      error_cnt++;
      finish_test();
   end
endmodule // tb_master_slave_pwm
bind master_slave_pwm pwm_props chk_u (.ref_clk_i(ref_clk_i),
   .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .pwm_out_o(pwm_out_o), .master_irq_o(master_irq_o),
   .slave_irq_o(slave_irq_o));
